// File: dss_pkg.sv
// constants and types shared by the ddr separate-io sram port logic
package dss_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 36;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int BURST_WORDS = 2;
   localparam int WORD_IDX_W = ADDR_W + 1;
   localparam int MEM_WORDS = BURST_WORDS << ADDR_W;
   localparam int SYNC_STAGES = 3;
   // pin group widths: four clocks plus single-mode strap, then the bus pins
   localparam int CLK_PINS_W = 5;
   localparam int BUS_PINS_W = 2 + LANES + ADDR_W + DATA_W;
   localparam logic [1:0] RD_IDLE_RST = 2'h0;

   typedef enum logic [1:0] {
      DSS_RD_IDLE = 2'b00,
      DSS_RD_WAIT = 2'b01,
      DSS_RD_WORD0 = 2'b10
   } dss_rd_e;
endpackage : dss_pkg

// File: dss_pin_sync.sv
// three-stage pin synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module dss_pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic [WIDTH-1:0] i_pins,
   output logic [WIDTH-1:0] o_stage2,
   output logic [WIDTH-1:0] o_stage3
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;

   // stage one feeds stage two only
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         // flush to the pin level so no false edge follows reset
         stage1_reg <= i_pins;
         stage2_reg <= i_pins;
         stage3_reg <= i_pins;
      end else begin
         stage1_reg <= i_pins;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   assign o_stage2 = stage2_reg;
   assign o_stage3 = stage3_reg;
endmodule : dss_pin_sync

// File: dss_sram_port.sv
// sram side of a ddr separate-io two-word burst port with its storage array
`timescale 1ns/1ps
module dss_sram_port (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_k,
   input wire logic i_k_n,
   input wire logic i_c,
   input wire logic i_c_n,
   input wire logic i_single_clk,
   input wire logic i_load_strobe_n,
   input wire logic i_dir_read,
   input wire logic [dss_pkg::LANES-1:0] i_lane_write_mask_n,
   input wire logic [dss_pkg::ADDR_W-1:0] i_addr,
   input wire logic [dss_pkg::DATA_W-1:0] i_data,
   output logic [dss_pkg::DATA_W-1:0] o_q,
   output logic o_q_oe
);
   // ---------------------------------------------------------------
   // pin capture
   // ---------------------------------------------------------------
   logic [dss_pkg::CLK_PINS_W-1:0] clk_s2;
   logic [dss_pkg::CLK_PINS_W-1:0] clk_s3;
   logic [dss_pkg::BUS_PINS_W-1:0] bus_s2;
   logic [dss_pkg::BUS_PINS_W-1:0] bus_s3;

   dss_pin_sync #(.WIDTH(dss_pkg::CLK_PINS_W)) u_clk_sync (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_pins({i_single_clk, i_c_n, i_c, i_k_n, i_k}),
      .o_stage2(clk_s2),
      .o_stage3(clk_s3)
   );

   // bus pins share the clock pins' latency so an edge sees its own data
   dss_pin_sync #(.WIDTH(dss_pkg::BUS_PINS_W)) u_bus_sync (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_pins({i_load_strobe_n, i_dir_read, i_lane_write_mask_n, i_addr, i_data}),
      .o_stage2(bus_s2),
      .o_stage3(bus_s3)
   );

   logic k_rise;
   logic kn_rise;
   logic out_rise;
   logic out_fall;
   logic single_mode;
   logic ld_n;
   logic dir_rd;
   logic [dss_pkg::LANES-1:0] mask_n;
   logic [dss_pkg::ADDR_W-1:0] addr;
   logic [dss_pkg::DATA_W-1:0] wdata;
   logic load_wr;
   logic load_rd;
   logic c_rise;
   logic cn_rise;
   logic [dss_pkg::CLK_PINS_W-1:0] clk_lvl;
   logic [dss_pkg::BUS_PINS_W-1:0] bus_lvl;

   typedef struct packed {
      logic [dss_pkg::CLK_PINS_W-1:0] clk_lvl;
      logic [dss_pkg::BUS_PINS_W-1:0] bus_lvl;
      logic wr_open;
      logic [dss_pkg::ADDR_W-1:0] wr_addr;
      logic rd_pend;
      logic [dss_pkg::DATA_W-1:0] rd_w0;
      logic [dss_pkg::DATA_W-1:0] rd_w1;
      dss_pkg::dss_rd_e out_st;
      logic [dss_pkg::DATA_W-1:0] q;
      logic q_oe;
   } dss_state_s;

   dss_state_s st_reg;
   dss_state_s st_next;

   // ---------------------------------------------------------------
   // pin level filter and edge decode
   // ---------------------------------------------------------------
   // a pin change counts only once stages two and three agree, so a
   // bit caught mid-flight never makes a one-cycle glitch edge
   always_comb begin
      clk_lvl = st_reg.clk_lvl;
      bus_lvl = st_reg.bus_lvl;
      for (int b = 0; b < dss_pkg::CLK_PINS_W; b++) begin
         if (clk_s2[b] == clk_s3[b]) begin
            clk_lvl[b] = clk_s3[b];
         end
      end
      for (int b = 0; b < dss_pkg::BUS_PINS_W; b++) begin
         if (bus_s2[b] == bus_s3[b]) begin
            bus_lvl[b] = bus_s3[b];
         end
      end
      k_rise = clk_lvl[0] & ~st_reg.clk_lvl[0];
      kn_rise = clk_lvl[1] & ~st_reg.clk_lvl[1];
      single_mode = clk_lvl[4];
      c_rise = clk_lvl[2] & ~st_reg.clk_lvl[2];
      cn_rise = clk_lvl[3] & ~st_reg.clk_lvl[3];
      // output pair supplied by controller for deskew, else primary pair
      out_rise = single_mode ? k_rise : c_rise;
      out_fall = single_mode ? kn_rise : cn_rise;
      {ld_n, dir_rd, mask_n, addr, wdata} = bus_lvl;
      load_wr = k_rise & ~ld_n & ~dir_rd;
      load_rd = k_rise & ~ld_n & dir_rd;
   end

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [dss_pkg::DATA_W-1:0] mem [dss_pkg::MEM_WORDS];
   logic we0;
   logic we1;
   logic [dss_pkg::WORD_IDX_W-1:0] widx0;
   logic [dss_pkg::WORD_IDX_W-1:0] widx1;
   logic [dss_pkg::WORD_IDX_W-1:0] ridx0;
   logic [dss_pkg::WORD_IDX_W-1:0] ridx1;

   always_comb begin
      // address is only looked at while a port is selected
      widx0 = {addr, 1'b0};
      widx1 = {st_reg.wr_addr, 1'b1};
      ridx0 = {addr, 1'b0};
      ridx1 = {addr, 1'b1};
      we0 = load_wr;
      we1 = kn_rise & st_reg.wr_open;
   end

   // each word carries its own mask, sampled with it
   always_ff @(posedge i_clk_sys) begin
      for (int l = 0; l < dss_pkg::LANES; l++) begin
         if (we0 && !mask_n[l]) begin
            mem[widx0][l*dss_pkg::LANE_W +: dss_pkg::LANE_W] <=
               wdata[l*dss_pkg::LANE_W +: dss_pkg::LANE_W];
         end
         if (we1 && !mask_n[l]) begin
            mem[widx1][l*dss_pkg::LANE_W +: dss_pkg::LANE_W] <=
               wdata[l*dss_pkg::LANE_W +: dss_pkg::LANE_W];
         end
      end
   end

   // ---------------------------------------------------------------
   // burst sequencing
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.clk_lvl = clk_lvl;
      st_next.bus_lvl = bus_lvl;
      // write burst: second word closes it on the complement edge
      if (we1) begin
         st_next.wr_open = 1'b0;
      end
      if (load_wr) begin
         st_next.wr_open = 1'b1;
         st_next.wr_addr = addr;
      end
      // read port
      case (st_reg.out_st)
         dss_pkg::DSS_RD_IDLE: begin
            // the last word stays driven until the next output rise
            st_next.q_oe = st_reg.q_oe;
         end
         dss_pkg::DSS_RD_WAIT: begin
            if (out_rise) begin
               st_next.q = st_reg.rd_w0;
               st_next.q_oe = 1'b1;
               st_next.rd_pend = 1'b0;
               st_next.out_st = dss_pkg::DSS_RD_WORD0;
            end
         end
         dss_pkg::DSS_RD_WORD0: begin
            if (out_fall) begin
               st_next.q = st_reg.rd_w1;
               st_next.out_st = st_reg.rd_pend ? dss_pkg::DSS_RD_WAIT : dss_pkg::DSS_RD_IDLE;
            end
         end
         default: begin
            st_next.out_st = dss_pkg::DSS_RD_IDLE;
         end
      endcase
      // a read already on the bus holds oe until its successor or the next rising edge
      if (st_reg.out_st == dss_pkg::DSS_RD_IDLE && st_reg.q_oe && out_rise) begin
         st_next.q_oe = 1'b0;
      end
      // new read wins over the pending clear in the same cycle
      if (load_rd) begin
         st_next.rd_w0 = mem[ridx0];
         st_next.rd_w1 = mem[ridx1];
         st_next.rd_pend = 1'b1;
         if (st_next.out_st == dss_pkg::DSS_RD_IDLE) begin
            st_next.out_st = dss_pkg::DSS_RD_WAIT;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st_reg <= '0;
         // start from the present pin levels so reset makes no false edge
         st_reg.clk_lvl <= clk_s3;
         st_reg.bus_lvl <= bus_s3;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_q = st_reg.q;
   assign o_q_oe = st_reg.q_oe;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic chk_valid;
   logic [dss_pkg::WORD_IDX_W-1:0] chk_idx;
   logic [dss_pkg::LANE_W-1:0] chk_old;

   // remembers lane 0 of a burst's first word written with lane 0 masked off
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         chk_valid <= 1'b0;
         chk_idx <= '0;
         chk_old <= '0;
      end else begin
         chk_valid <= we0 && mask_n[0] && !(we1 && widx1 == widx0);
         chk_idx <= widx0;
         chk_old <= mem[widx0][dss_pkg::LANE_W-1:0];
      end
   end

   masked_lane_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      chk_valid |-> mem[chk_idx][dss_pkg::LANE_W-1:0] == chk_old)
      else $error("masked lane was overwritten");

   idle_float_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (st_reg.out_st == dss_pkg::DSS_RD_IDLE && out_rise) |=> !o_q_oe)
      else $error("read data driven while port deselected");

   first_word_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (st_reg.out_st == dss_pkg::DSS_RD_WAIT && out_rise) |=> o_q_oe && o_q == $past(st_reg.rd_w0))
      else $error("first read word not driven on output rising edge");

   second_word_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (st_reg.out_st == dss_pkg::DSS_RD_WORD0 && out_fall) |=> o_q == $past(st_reg.rd_w1))
      else $error("second read word out of order");

   write_open_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      load_wr |=> st_reg.wr_open ##0 st_reg.wr_addr == $past(addr))
      else $error("write burst not opened on true clock edge");

   write_close_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (we1 && !load_wr) |=> !st_reg.wr_open)
      else $error("write burst longer than two words");

   no_load_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (k_rise && ld_n && !st_reg.wr_open) |=> !st_reg.wr_open && $stable(st_reg.wr_addr))
      else $error("transaction started with load strobe high");

   addr_ignored_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $changed(st_reg.wr_addr) |-> $past(load_wr))
      else $error("address taken while port deselected");

   read_start_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $rose(st_reg.rd_pend) |-> $past(load_rd))
      else $error("read started off the true clock rising edge");

   // ---------------------------------------------------------------
   // output, edge and burst checks
   // ---------------------------------------------------------------
   q_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (!out_rise && !out_fall) |=> $stable(o_q))
      else $error("read data changed without an output edge");

   oe_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (!out_rise && !out_fall) |=> $stable(o_q_oe))
      else $error("read enable changed without an output edge");

   oe_start_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $rose(o_q_oe) |-> $past(out_rise))
      else $error("read enable rose off an output rising edge");

   read_pend_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      load_rd |=> st_reg.rd_pend)
      else $error("read load not recorded");

   read_no_write_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (load_rd && !st_reg.wr_open) |=> !st_reg.wr_open)
      else $error("read load opened a write burst");

   burst_end_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (st_reg.out_st == dss_pkg::DSS_RD_WORD0 && out_fall && !st_reg.rd_pend && !load_rd)
         |=> st_reg.out_st == dss_pkg::DSS_RD_IDLE)
      else $error("read burst longer than two words");

   idle_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      st_reg.out_st == dss_pkg::DSS_RD_IDLE |-> !st_reg.rd_pend)
      else $error("read left pending with the port idle");

   k_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      k_rise |=> !k_rise)
      else $error("true clock edge seen twice");

   pin_filter_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (clk_s2[0] != clk_s3[0]) |=> $stable(st_reg.clk_lvl[0]))
      else $error("clock level followed a disagreeing sync stage");

   second_lane_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (we1 && !mask_n[0])
         |=> mem[$past(widx1)][dss_pkg::LANE_W-1:0] == $past(wdata[dss_pkg::LANE_W-1:0]))
      else $error("second word lane not written with its own mask");
endmodule : dss_sram_port

// File: dss_ctrl_model.sv
// behavioural memory controller driving the sram pins
`timescale 1ns/1ps
module dss_ctrl_model (
   input wire logic i_clk_sys,
   input wire logic i_single_clk,
   output logic o_k,
   output logic o_k_n,
   output logic o_c,
   output logic o_c_n,
   output logic o_load_strobe_n,
   output logic o_dir_read,
   output logic [3:0] o_lane_write_mask_n,
   output logic [18:0] o_addr,
   output logic [35:0] o_data,
   output logic o_look
);
   // clocks stand still between frames
   initial begin
      {o_k, o_k_n, o_c, o_c_n, o_load_strobe_n, o_dir_read, o_look} = 7'b0101100;
      {o_lane_write_mask_n, o_addr, o_data} = '0;
   end

   // edges are seen late through the pin syncs; flag where a result is settled
   task automatic settle(input logic out_edge);
      repeat (4) @(negedge i_clk_sys);
      o_look = out_edge;
      @(negedge i_clk_sys);
      o_look = 1'b0;
   endtask : settle

   task automatic kpulse(input logic ld_n, input logic rd, input logic [18:0] a,
      input logic [35:0] d0, input logic [3:0] m0, input logic [35:0] d1,
      input logic [3:0] m1);
      @(negedge i_clk_sys);
      o_load_strobe_n = ld_n;
      o_dir_read = rd;
      o_addr = a;
      o_data = d0;
      o_lane_write_mask_n = m0;
      repeat (3) @(negedge i_clk_sys);
      o_k = 1'b1;
      o_k_n = 1'b0;
      settle(i_single_clk);
      o_load_strobe_n = 1'b1;
      o_addr = ~a;
      o_dir_read = ~rd;
      o_data = d1;
      o_lane_write_mask_n = m1;
      repeat (3) @(negedge i_clk_sys);
      o_k = 1'b0;
      o_k_n = 1'b1;
      settle(i_single_clk);
      // released lines must not keep the last value
      o_data = ~d1;
      o_lane_write_mask_n = ~m1;
   endtask : kpulse

   task automatic cpulse();
      repeat (4) @(negedge i_clk_sys);
      o_c = 1'b1;
      o_c_n = 1'b0;
      settle(!i_single_clk);
      repeat (3) @(negedge i_clk_sys);
      o_c = 1'b0;
      o_c_n = 1'b1;
      settle(!i_single_clk);
   endtask : cpulse
endmodule : dss_ctrl_model

// File: test_ddr_sio_sram_port_signals.sv
// self-checking bench for the ddr separate-io sram port
`timescale 1ns/1ps
module test_ddr_sio_sram_port_signals;
   logic i_clk_sys, i_sys_rst, i_single_clk, k, k_n, c, c_n, ld_n, rd, look, o_q_oe;
   logic [3:0] m;
   logic [18:0] a;
   logic [35:0] o_q, d;
   logic [36:0] exp_q[$];
   logic [35:0] mem[logic [19:0]];
   int error_cnt = 0, tests_run = 0, cyc = 0, seed = 32'h3b06;

   dss_ctrl_model dss_ctrl_model_i (.i_clk_sys, .i_single_clk, .o_k(k), .o_k_n(k_n),
      .o_c(c), .o_c_n(c_n), .o_load_strobe_n(ld_n), .o_dir_read(rd),
      .o_lane_write_mask_n(m), .o_addr(a), .o_data(d), .o_look(look));
   dss_sram_port dss_sram_port_i (.i_clk_sys, .i_sys_rst, .i_k(k), .i_k_n(k_n), .i_c(c),
      .i_c_n(c_n), .i_single_clk, .i_load_strobe_n(ld_n), .i_dir_read(rd),
      .i_lane_write_mask_n(m), .i_addr(a), .i_data(d), .o_q,
      .o_q_oe);

   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out

   task automatic check(input logic [36:0] seen, input logic [36:0] want);
      tests_run++;
      if (seen !== want) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask : check

   // -----------------------------------------
   // result watcher and hang guard
   // -----------------------------------------
   always @(posedge i_clk_sys) begin
      cyc++;
      if (look === 1'b1 && exp_q.size() > 0) begin
         if (exp_q[0][36]) check({o_q_oe, o_q}, exp_q[0]);
         else check({o_q_oe, 36'h0}, exp_q[0]);
         void'(exp_q.pop_front());
      end
      if (cyc == 30000) begin
         error_cnt++;
         close_out();
      end
   end

   function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw,
      input logic [3:0] mn);
      for (int l = 0; l < 4; l++) if (!mn[l]) old[9*l +: 9] = nw[9*l +: 9];
      return old;
   endfunction : merge

   function automatic logic [35:0] rnd();
      return 36'({$random(seed), $random(seed)});
   endfunction : rnd

   task automatic wr(input logic [18:0] ad, input logic [35:0] d0, input logic [3:0] m0,
      input logic [35:0] d1, input logic [3:0] m1);
      mem[{ad, 1'b0}] = merge(mem[{ad, 1'b0}], d0, m0);
      mem[{ad, 1'b1}] = merge(mem[{ad, 1'b1}], d1, m1);
      dss_ctrl_model_i.kpulse(1'b0, 1'b0, ad, d0, m0, d1, m1);
   endtask : wr

   task automatic rd_c(input logic [18:0] ad);
      dss_ctrl_model_i.kpulse(1'b0, 1'b1, ad, rnd(), 4'h0, rnd(), 4'h0);
      exp_q.push_back({1'b1, mem[{ad, 1'b0}]});
      exp_q.push_back({1'b1, mem[{ad, 1'b1}]});
      dss_ctrl_model_i.cpulse();
      exp_q.push_back(37'h0);
      dss_ctrl_model_i.cpulse();
   endtask : rd_c

   task automatic idle(input logic [18:0] ad);
      dss_ctrl_model_i.kpulse(1'b1, 1'b0, ad, rnd(), 4'h0, rnd(), 4'h0);
   endtask : idle

   // -----------------------------------------
   // main sequence
   // -----------------------------------------
   initial begin
      logic [18:0] ad;
      i_sys_rst = 1'b1;
      i_single_clk = 1'b0;
      repeat (12) @(negedge i_clk_sys);
      i_sys_rst = 1'b0;
      check({o_q_oe, o_q}, 37'h0);
      for (int i = 0; i < 5; i++) begin
         ad = (i == 0) ? 19'h0 : (i == 1) ? 19'h7FFFF : 19'($random(seed));
         wr(ad, rnd(), 4'h0, rnd(), 4'h0);
         wr(ad, rnd(), (i == 2) ? 4'hF : 4'($random(seed)), rnd(), 4'($random(seed)));
         idle(ad);
         rd_c(ad);
      end
      // single clock mode: reads are timed from the primary clocks
      i_single_clk = 1'b1;
      repeat (8) @(negedge i_clk_sys);
      dss_ctrl_model_i.kpulse(1'b0, 1'b1, ad, rnd(), 4'h0, rnd(), 4'h0);
      exp_q.push_back({1'b1, mem[{ad, 1'b0}]});
      exp_q.push_back({1'b1, mem[{ad, 1'b1}]});
      idle(ad);
      exp_q.push_back(37'h0);
      idle(ad);
      check(37'(exp_q.size()), 37'h0);
      close_out();
   end
endmodule : test_ddr_sio_sram_port_signals
